// >>> verilog/spcu_pkg.sv
// Purpose: constants, register map and state codes of the serial port control block
// Assumes: 10 MHz cpu clock, 8-bit register port, timer overflow tick supplied from outside
// Notes: frame and rate figures below are shared by the core and its helpers
// Notes on behaviour
// (R01) control bit 7 reads framing error when frame_error_select is 1, else mode_select_high
// (R02) framing error flag set on bad stop bit, sticky until software clears it
// (R03) mode bits pick shift register, 8-bit variable, 9-bit fixed or 9-bit variable
// (R04) modes 2/3 with multiproc_enable: no rx done when received ninth bit is 0
// (R05) mode 1 with multiproc_enable: no rx done unless stop bit valid
// (R06) software should keep multiproc_enable at 0 in mode 0
// (R07) reception only while receive enable is set by software
// (R08) modes 2/3 transmit tx_ninth_bit as ninth data bit
// (R09) rx_ninth_bit takes ninth bit in modes 2/3, stop bit in mode 1
// (R10) tx done set after 8th bit in mode 0, at stop bit start otherwise
// (R11) rx done set after 8th bit in mode 0, mid stop bit otherwise, filtered
// (R12) mode 2 rate is clock/32, or clock/16 with rate_double set
// (R13) mode 0 shift rate fixed at clock/6
// (R14) mode 1 frame: start low, eight data lsb first, stop high
// (R15) modes 2/3 frame: start, eight data lsb first, ninth bit, stop
// (R16) data write starts transmit; receive starts per mode when enabled
// (R17) receive buffer overwritten when a second byte completes unread
// (R18) variable modes use outside timer tick, bits sampled near centre
package spcu_pkg;
  // register offsets
  localparam logic [7:0] SPCU_CTRL_ADDR = 8'h98;
  localparam logic [7:0] SPCU_DATA_ADDR = 8'h99;
  localparam logic [7:0] SPCU_PWR_ADDR = 8'h87;
  // reset values
  localparam logic [7:0] SPCU_CTRL_RESET = 8'h00;
  localparam logic [7:0] SPCU_DATA_RESET = 8'h00;
  // control register field positions
  localparam int SPCU_B_MODEH = 7;
  localparam int SPCU_B_MODEL = 6;
  localparam int SPCU_B_MPEN = 5;
  localparam int SPCU_B_REN = 4;
  localparam int SPCU_B_TXNINTH = 3;
  localparam int SPCU_B_RXNINTH = 2;
  localparam int SPCU_B_TXDONE = 1;
  localparam int SPCU_B_RXDONE = 0;
  // power control field positions
  localparam int SPCU_B_RATE2 = 7;
  localparam int SPCU_B_FESEL = 6;
  // serial modes
  typedef logic [1:0] spcu_mode_t;
  localparam spcu_mode_t SPCU_MODE_SHIFT = 2'h0;
  localparam spcu_mode_t SPCU_MODE_UART8 = 2'h1;
  localparam spcu_mode_t SPCU_MODE_UART9F = 2'h2;
  localparam spcu_mode_t SPCU_MODE_UART9V = 2'h3;
  // timing counts
  localparam int SPCU_M0_DIV = 6;
  localparam logic [3:0] SPCU_M0_LAST = 4'(SPCU_M0_DIV - 1);
  localparam logic [3:0] SPCU_M0_HIGH = 4'(SPCU_M0_DIV / 2);
  localparam logic [3:0] SPCU_M0_BITS = 4'h8;
  localparam int SPCU_PRE_DIV = 2;
  localparam logic [3:0] SPCU_OVS_LAST = 4'hF;
  localparam logic [3:0] SPCU_VOTE_PH = 4'h9;
  localparam logic [3:0] SPCU_BITS8 = 4'hA;
  localparam logic [3:0] SPCU_BITS9 = 4'hB;
  // state machines
  typedef enum logic [2:0] {
    SPCU_TX_IDLE = 3'b001,
    SPCU_TX_SHIFT = 3'b010,
    SPCU_TX_ASYNC = 3'b100
  } spcu_tx_e;
  typedef enum logic [2:0] {
    SPCU_RX_IDLE = 3'b001,
    SPCU_RX_SHIFT = 3'b010,
    SPCU_RX_FRAME = 3'b100
  } spcu_rx_e;
endpackage

// >>> verilog/spcu_div.sv
// Purpose: divide a stream of enable pulses by a fixed ratio
// Assumes: en is a one-cycle pulse or a constant high
// Notes: tick is combinational and lasts one cycle
`timescale 1ns/10ps
`default_nettype none
module spcu_div #(parameter int DIV = 2) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pulse in and out
  input wire logic en,
  output logic tick
);
  localparam int W = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_r;

  // free running count of enable pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (en) begin
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end

  assign tick = en && (cnt_r == LAST);
endmodule
`default_nettype wire

// >>> verilog/spcu_vote.sv
// Purpose: majority of three consecutive samples of the receive line
// Assumes: sample_en marks each oversampling point
// Notes: vote uses the two stored samples plus the present one
`timescale 1ns/10ps
`default_nettype none
module spcu_vote (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sampling
  input wire logic sample_en,
  input wire logic din,
  output logic vote
);
  logic [1:0] hist_r;

  // two most recent samples, idle line is high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hist_r <= 2'h3;
    end else if (sample_en) begin
      hist_r <= {hist_r[0], din};
    end
  end

  // a single glitch cannot flip the bit
  assign vote = (hist_r[1] & hist_r[0]) | (hist_r[1] & din) | (hist_r[0] & din);
endmodule
`default_nettype wire

// >>> verilog/spcu_top.sv
// Purpose: serial port control, status and framing with its register port
// Assumes: register strobes one cycle, timer_tick one-cycle pulse per timer overflow
// Notes: mode 0 uses the receive pin for data and the transmit pin as shift clock
`timescale 1ns/10ps
`default_nettype none
module spcu_top import spcu_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // bit rate reference for modes 1 and 3
  input wire logic timer_tick,
  // serial pins
  output logic txd_out,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe
);
  // software state
  spcu_mode_t mode_r;
  logic mp_en_r;
  logic ren_r;
  logic tx_ninth_bit_r;
  logic rx_ninth_bit_r;
  logic tx_done_r;
  logic rx_done_r;
  logic frame_err_r;
  logic err_view_r;
  logic rate_dbl_r;
  logic [7:0] rx_buf_r;
  // decoded strobes
  logic wr_ctrl;
  logic wr_data;
  logic wr_pwr;
  // rate ticks
  logic pre_tick;
  logic tmr_half;
  logic s_tick;
  // transmitter
  spcu_tx_e tx_state_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_ph_r;
  logic [3:0] tx_bit_r;
  logic tx_start;
  logic tx_done_set;
  // receiver
  spcu_rx_e rx_state_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_ph_r;
  logic [3:0] rx_bit_r;
  logic rxd_prev_r;
  logic vote;
  logic [3:0] frame_bits;
  logic m0_done;
  logic stop_ev;
  logic rx_ninth;
  logic rx_accept;
  logic [7:0] rx_data;
  logic frame_err_set;
  logic m0_clk;

  // register decode
  assign wr_ctrl = reg_wr && (reg_addr == SPCU_CTRL_ADDR);
  assign wr_data = reg_wr && (reg_addr == SPCU_DATA_ADDR);
  assign wr_pwr = reg_wr && (reg_addr == SPCU_PWR_ADDR);

  // fixed prescale of the cpu clock for mode 2
  spcu_div #(.DIV(SPCU_PRE_DIV)) u_pre_div (
    .clk(clk),
    .arst_n(arst_n),
    .en(1'b1),
    .tick(pre_tick)
  );

  // halve timer overflows unless rate_double is set
  spcu_div #(.DIV(SPCU_PRE_DIV)) u_tmr_div (
    .clk(clk),
    .arst_n(arst_n),
    .en(timer_tick),
    .tick(tmr_half)
  );

  // sixteen ticks per bit in every asynchronous mode
  always_comb begin
    if (mode_r == SPCU_MODE_UART9F) begin
      s_tick = rate_dbl_r | pre_tick; // R12
    end else begin
      s_tick = rate_dbl_r ? timer_tick : tmr_half; // R18
    end
  end

  // frame length, 10 bits in mode 1, 11 in modes 2 and 3
  assign frame_bits = (mode_r == SPCU_MODE_UART8) ? SPCU_BITS8 : SPCU_BITS9; // R14 R15

  // mode and option bits; bit 7 writes whichever field is visible
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= SPCU_CTRL_RESET[SPCU_B_MODEH:SPCU_B_MODEL];
      mp_en_r <= SPCU_CTRL_RESET[SPCU_B_MPEN];
      ren_r <= SPCU_CTRL_RESET[SPCU_B_REN];
      tx_ninth_bit_r <= SPCU_CTRL_RESET[SPCU_B_TXNINTH];
    end else if (wr_ctrl) begin
      if (!err_view_r) begin
        mode_r[1] <= reg_wdata[SPCU_B_MODEH]; // R01
      end
      mode_r[0] <= reg_wdata[SPCU_B_MODEL]; // R03
      mp_en_r <= reg_wdata[SPCU_B_MPEN];
      ren_r <= reg_wdata[SPCU_B_REN]; // R07
      tx_ninth_bit_r <= reg_wdata[SPCU_B_TXNINTH];
    end
  end

  // power control bits that belong to the serial port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_view_r <= 1'b0;
      rate_dbl_r <= 1'b0;
    end else if (wr_pwr) begin
      err_view_r <= reg_wdata[SPCU_B_FESEL];
      rate_dbl_r <= reg_wdata[SPCU_B_RATE2];
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_err_r <= 1'b0;
      tx_done_r <= SPCU_CTRL_RESET[SPCU_B_TXDONE];
      rx_done_r <= SPCU_CTRL_RESET[SPCU_B_RXDONE];
    end else begin
      if (frame_err_set) begin
        frame_err_r <= 1'b1; // R02
      end else if (wr_ctrl && err_view_r) begin
        frame_err_r <= reg_wdata[SPCU_B_MODEH];
      end
      if (tx_done_set) begin
        tx_done_r <= 1'b1; // R10
      end else if (wr_ctrl) begin
        tx_done_r <= reg_wdata[SPCU_B_TXDONE];
      end
      if (rx_accept) begin
        rx_done_r <= 1'b1; // R11
      end else if (wr_ctrl) begin
        rx_done_r <= reg_wdata[SPCU_B_RXDONE];
      end
    end
  end

  // received byte and ninth bit, last completed frame wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buf_r <= SPCU_DATA_RESET;
      rx_ninth_bit_r <= SPCU_CTRL_RESET[SPCU_B_RXNINTH];
    end else begin
      if (rx_accept) begin
        rx_buf_r <= rx_data; // R17
      end
      if (rx_accept && !m0_done) begin
        rx_ninth_bit_r <= rx_ninth; // R09
      end else if (wr_ctrl) begin
        rx_ninth_bit_r <= reg_wdata[SPCU_B_RXNINTH];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SPCU_CTRL_ADDR: reg_rdata <= {err_view_r ? frame_err_r : mode_r[1], mode_r[0], mp_en_r, ren_r,
                                      tx_ninth_bit_r, rx_ninth_bit_r, tx_done_r, rx_done_r}; // R01
        SPCU_DATA_ADDR: reg_rdata <= rx_buf_r;
        SPCU_PWR_ADDR: reg_rdata <= {rate_dbl_r, err_view_r, 6'h00};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // a write while busy is dropped; mode 0 shares one data pin so rx blocks tx
  assign tx_start = wr_data && (tx_state_r == SPCU_TX_IDLE) && (rx_state_r != SPCU_RX_SHIFT); // R16

  // transmit sequencer: mode 0 bit is six clocks, async bit sixteen ticks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_r <= SPCU_TX_IDLE;
      tx_sh_r <= 11'h7FF;
      tx_ph_r <= 4'h0;
      tx_bit_r <= 4'h0;
    end else begin
      unique case (tx_state_r)
        SPCU_TX_IDLE: begin
          if (tx_start) begin
            tx_ph_r <= 4'h0;
            tx_bit_r <= 4'h0;
            if (mode_r == SPCU_MODE_SHIFT) begin
              tx_sh_r <= {3'h7, reg_wdata};
              tx_state_r <= SPCU_TX_SHIFT; // R03
            end else begin
              tx_sh_r <= {1'b1, (mode_r == SPCU_MODE_UART8) ? 1'b1 : tx_ninth_bit_r, reg_wdata, 1'b0}; // R08 R14 R15
              tx_state_r <= SPCU_TX_ASYNC;
            end
          end
        end
        SPCU_TX_SHIFT: begin
          if (tx_ph_r == SPCU_M0_LAST) begin
            tx_ph_r <= 4'h0; // R13
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == SPCU_M0_BITS - 4'h1) begin
              tx_state_r <= SPCU_TX_IDLE;
            end
          end else begin
            tx_ph_r <= tx_ph_r + 4'h1;
          end
        end
        SPCU_TX_ASYNC: begin
          if (s_tick) begin
            if (tx_ph_r == SPCU_OVS_LAST) begin
              tx_ph_r <= 4'h0;
              tx_sh_r <= {1'b1, tx_sh_r[10:1]};
              tx_bit_r <= tx_bit_r + 4'h1;
              if (tx_bit_r == frame_bits - 4'h1) begin
                tx_state_r <= SPCU_TX_IDLE;
              end
            end else begin
              tx_ph_r <= tx_ph_r + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // end of 8th shift bit, or the move onto the stop bit
  assign tx_done_set = ((tx_state_r == SPCU_TX_SHIFT) && (tx_ph_r == SPCU_M0_LAST)
                        && (tx_bit_r == SPCU_M0_BITS - 4'h1))
                    || ((tx_state_r == SPCU_TX_ASYNC) && s_tick && (tx_ph_r == SPCU_OVS_LAST)
                        && (tx_bit_r == frame_bits - 4'h2)); // R10

  // three samples around the bit centre
  spcu_vote u_vote (
    .clk(clk),
    .arst_n(arst_n),
    .sample_en(s_tick),
    .din(rxd_in),
    .vote(vote)
  );

  // edge detect on the receive line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_prev_r <= 1'b1;
    end else begin
      rxd_prev_r <= rxd_in;
    end
  end

  // receive sequencer; dropping receive enable abandons a frame at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_r <= SPCU_RX_IDLE;
      rx_sh_r <= 9'h000;
      rx_ph_r <= 4'h0;
      rx_bit_r <= 4'h0;
    end else if (!ren_r) begin
      rx_state_r <= SPCU_RX_IDLE; // R07
    end else begin
      unique case (rx_state_r)
        SPCU_RX_IDLE: begin
          rx_ph_r <= 4'h0;
          rx_bit_r <= 4'h0;
          if (mode_r == SPCU_MODE_SHIFT) begin
            if (!rx_done_r && (tx_state_r == SPCU_TX_IDLE) && !tx_start) begin
              rx_state_r <= SPCU_RX_SHIFT; // R16
            end
          end else if (rxd_prev_r && !rxd_in) begin
            rx_state_r <= SPCU_RX_FRAME; // R16
          end
        end
        SPCU_RX_SHIFT: begin
          if (rx_ph_r == SPCU_M0_LAST) begin
            rx_ph_r <= 4'h0;
            rx_sh_r <= {rxd_in, rx_sh_r[8:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == SPCU_M0_BITS - 4'h1) begin
              rx_state_r <= SPCU_RX_IDLE;
            end
          end else begin
            rx_ph_r <= rx_ph_r + 4'h1;
          end
        end
        SPCU_RX_FRAME: begin
          if (s_tick) begin
            rx_ph_r <= (rx_ph_r == SPCU_OVS_LAST) ? 4'h0 : rx_ph_r + 4'h1;
            if (rx_ph_r == SPCU_OVS_LAST) begin
              rx_bit_r <= rx_bit_r + 4'h1;
            end
            if (rx_ph_r == SPCU_VOTE_PH) begin
              // a start bit that reads high at its centre was noise
              if ((rx_bit_r == 4'h0) && vote) begin
                rx_state_r <= SPCU_RX_IDLE; // R18
              end else if (rx_bit_r == frame_bits - 4'h1) begin
                rx_state_r <= SPCU_RX_IDLE;
              end else if (rx_bit_r != 4'h0) begin
                rx_sh_r <= {vote, rx_sh_r[8:1]};
              end
            end
          end
        end
      endcase
    end
  end

  // completion events
  assign m0_done = ren_r && (rx_state_r == SPCU_RX_SHIFT) && (rx_ph_r == SPCU_M0_LAST)
                && (rx_bit_r == SPCU_M0_BITS - 4'h1); // R11
  assign stop_ev = ren_r && (rx_state_r == SPCU_RX_FRAME) && s_tick && (rx_ph_r == SPCU_VOTE_PH)
                && (rx_bit_r == frame_bits - 4'h1); // R11
  // ninth data bit in modes 2/3, stop bit in mode 1
  assign rx_ninth = mode_r[1] ? rx_sh_r[8] : vote; // R09
  assign frame_err_set = stop_ev && !vote; // R02

  // multiprocessor filter gates only the completion, never the framing check
  assign rx_accept = m0_done || (stop_ev && (!mp_en_r || rx_ninth)); // R04 R05

  // byte position depends on how many bits were shifted in
  always_comb begin
    if (m0_done) begin
      rx_data = {rxd_in, rx_sh_r[8:2]};
    end else if (mode_r[1]) begin
      rx_data = rx_sh_r[7:0];
    end else begin
      rx_data = rx_sh_r[8:1];
    end
  end

  // mode 0 shift clock low for the first half of each bit
  assign m0_clk = (tx_state_r == SPCU_TX_SHIFT) ? (tx_ph_r >= SPCU_M0_HIGH) : (rx_ph_r >= SPCU_M0_HIGH);

  // pins registered; idle lines rest high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
    end else begin
      if (tx_state_r == SPCU_TX_ASYNC) begin
        txd_out <= tx_sh_r[0];
      end else if ((tx_state_r == SPCU_TX_SHIFT) || (rx_state_r == SPCU_RX_SHIFT)) begin
        txd_out <= m0_clk; // R13
      end else begin
        txd_out <= 1'b1;
      end
      rxd_out <= (tx_state_r == SPCU_TX_SHIFT) ? tx_sh_r[0] : 1'b1;
      rxd_oe <= (tx_state_r == SPCU_TX_SHIFT);
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence m0_bit_seq;
    (tx_ph_r == 4'h1) ##1 (tx_ph_r == 4'h2) ##1 (tx_ph_r == 4'h3) ##1 (tx_ph_r == 4'h4)
      ##1 (tx_ph_r == SPCU_M0_LAST);
  endsequence

  sequence m2_slow_seq;
    (mode_r == SPCU_MODE_UART9F) && !rate_dbl_r && s_tick ##1 (mode_r == SPCU_MODE_UART9F) && !rate_dbl_r;
  endsequence

  a_bit7_view: assert property (reg_rd && (reg_addr == SPCU_CTRL_ADDR) // R01
    |=> reg_rdata[7] == ($past(err_view_r) ? $past(frame_err_r) : $past(mode_r[1])))
    else $error("control bit 7 shows wrong field");
  a_err_sticky: assert property (frame_err_r && !(wr_ctrl && err_view_r) |=> frame_err_r) // R02
    else $error("framing error cleared without software");
  a_err_bad_stop: assert property (stop_ev && !vote |=> frame_err_r) // R02
    else $error("bad stop bit not flagged");
  a_mode0_start: assert property (tx_start && (mode_r == SPCU_MODE_SHIFT) |=> tx_state_r == SPCU_TX_SHIFT) // R03
    else $error("mode 0 write did not start shifting");
  a_mp_ninth: assert property (stop_ev && mode_r[1] && mp_en_r && !rx_sh_r[8] && !m0_done |-> !rx_accept) // R04
    else $error("address filter let a data frame through");
  a_mp_stop: assert property (stop_ev && (mode_r == SPCU_MODE_UART8) && mp_en_r && !vote |-> !rx_accept) // R05
    else $error("mode 1 filter ignored bad stop");
  a_ren_gate: assert property (!ren_r |=> rx_state_r == SPCU_RX_IDLE) // R07
    else $error("receiver active without enable");
  a_tx_ninth: assert property (tx_start && mode_r[1] |=> tx_sh_r[9] == $past(tx_ninth_bit_r) && !tx_sh_r[0]) // R08
    else $error("ninth transmit bit not loaded");
  a_rxninth_load: assert property (rx_accept && !m0_done && mode_r[1] |=> rx_ninth_bit_r == $past(rx_sh_r[8])) // R09
    else $error("ninth receive bit not captured");
  a_txdone_timing: assert property (tx_done_set |=> tx_done_r && (tx_state_r != SPCU_TX_SHIFT)) // R10
    else $error("tx done not set at bit boundary");
  a_rxdone_timing: assert property (rx_accept |=> rx_done_r && rx_buf_r == $past(rx_data)) // R11 R17
    else $error("rx done or buffer not updated");
  a_m2_rate: assert property (m2_slow_seq |-> !s_tick) // R12
    else $error("mode 2 tick too fast");
  a_m0_rate: assert property ((tx_state_r == SPCU_TX_SHIFT) && (tx_ph_r == 4'h0) ##1 (tx_state_r == SPCU_TX_SHIFT)
    |-> m0_bit_seq ##1 ((tx_ph_r == 4'h0) || (tx_state_r == SPCU_TX_IDLE))) // R13
    else $error("mode 0 bit not six clocks");
  a_frame_len: assert property (tx_start && (mode_r == SPCU_MODE_UART8) |=> tx_sh_r[9] && tx_sh_r[10]) // R14
    else $error("mode 1 frame lacks stop bit");
endmodule
`default_nettype wire

// >>> testbench/spcu_peer.sv
// Purpose: remote serial transceiver on the transmit and receive lines
// Assumes: caller gives bit length in cpu clocks and the frame bits start bit first
// Notes: the receive line idles high between frames, as a pulled-up line would
`timescale 1ns/10ps
`default_nettype none
module spcu_peer (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;

  // capture one frame, each bit sampled at its centre so a wrong rate shows
  task automatic take(input int n, input int bt, output logic [10:0] bits);
    bits = 11'h000;
    @(negedge txd);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (bt) @(posedge clk);
    end
  endtask

  // send one frame, then a full idle bit so the next start edge is clean
  task automatic give(input int n, input int bt, input logic [10:0] bits);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bt) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (bt) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> testbench/spcu_top_tb.sv
// Purpose: register-level regression of the serial port control block
// Assumes: peer model on the serial pins, timer tick high every second clock
// Notes: only mismatches and the verdict are printed
`timescale 1ns/10ps
`default_nettype none
module spcu_top_tb;
  import spcu_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic timer_tick = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic txd_out, rxd_out, rxd_oe, peer_rxd, rxd_line;
  logic [10:0] bits;
  int fails = 0;
  int checked = 0;
  time t0;

  // pin level: the block wins only while it drives in mode 0
  assign rxd_line = rxd_oe ? rxd_out : peer_rxd;
  always #50 clk = ~clk;
  // overflow pulse on every second clock
  always @(posedge clk) timer_tick <= ~timer_tick;

  spcu_top dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_tick(timer_tick), .txd_out(txd_out), .rxd_in(rxd_line),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe));
  spcu_peer peer_u (.clk(clk), .txd(txd_out), .rxd(peer_rxd));

  task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] v;
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    chk(name, {3'h0, exp}, {3'h0, v & m});
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // about a dozen frames of at most 704 clocks each, with ample margin
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rdc("control reset", SPCU_CTRL_ADDR, 8'hFF, 8'h00);
    rdc("unmapped read", 8'h80, 8'hFF, 8'h00);
    // mode 2 transmit at both fixed rates, ninth bit both ways
    for (int r = 0; r < 2; r++) begin
      wr(SPCU_PWR_ADDR, r ? 8'h80 : 8'h00);
      wr(SPCU_CTRL_ADDR, {4'h8, r[0], 3'h0});
      fork
        peer_u.take(11, r ? 16 : 32, bits);
        wr(SPCU_DATA_ADDR, r ? 8'h3C : 8'hA5);
      join
      chk("mode 2 frame", {1'b1, r[0], r ? 8'h3C : 8'hA5, 1'b0}, bits);
      rdc("tx done", SPCU_CTRL_ADDR, 8'hFF, {4'h8, r[0], 3'h2});
      wr(SPCU_CTRL_ADDR, {4'h8, r[0], 3'h0});
      rdc("tx done cleared", SPCU_CTRL_ADDR, 8'h02, 8'h00);
    end
    // mode 2 receive with the address filter on
    wr(SPCU_PWR_ADDR, 8'h80);
    wr(SPCU_CTRL_ADDR, 8'hB0);
    peer_u.give(11, 16, {2'b11, 8'h5A, 1'b0});
    rdc("rx status", SPCU_CTRL_ADDR, 8'hFF, 8'hB5);
    rdc("rx byte", SPCU_DATA_ADDR, 8'hFF, 8'h5A);
    wr(SPCU_CTRL_ADDR, 8'hB0);
    peer_u.give(11, 16, {2'b10, 8'h11, 1'b0});
    rdc("filtered frame", SPCU_CTRL_ADDR, 8'h01, 8'h00);
    rdc("kept byte", SPCU_DATA_ADDR, 8'hFF, 8'h5A);
    wr(SPCU_CTRL_ADDR, 8'hA0);
    peer_u.give(11, 16, {2'b11, 8'h22, 1'b0});
    rdc("receive disabled", SPCU_CTRL_ADDR, 8'h01, 8'h00);
    // framing error view of bit 7, stickiness and overwrite
    wr(SPCU_CTRL_ADDR, 8'hB0);
    wr(SPCU_PWR_ADDR, 8'hC0);
    rdc("error view clear", SPCU_CTRL_ADDR, 8'h80, 8'h00);
    peer_u.give(11, 16, {2'b01, 8'h33, 1'b0});
    peer_u.give(11, 16, {2'b11, 8'h44, 1'b0});
    rdc("error sticky", SPCU_CTRL_ADDR, 8'h80, 8'h80);
    rdc("overwrite", SPCU_DATA_ADDR, 8'hFF, 8'h44);
    wr(SPCU_CTRL_ADDR, 8'h30);
    rdc("error cleared", SPCU_CTRL_ADDR, 8'h80, 8'h00);
    wr(SPCU_PWR_ADDR, 8'h80);
    rdc("mode high view", SPCU_CTRL_ADDR, 8'h80, 8'h80);
    // mode 1 on the timer tick, stop bit filter
    wr(SPCU_CTRL_ADDR, 8'h70);
    peer_u.give(10, 32, {3'b000, 8'h66, 1'b0});
    rdc("mode 1 filter", SPCU_CTRL_ADDR, 8'h01, 8'h00);
    peer_u.give(10, 32, {3'b001, 8'h69, 1'b0});
    rdc("mode 1 rx", SPCU_CTRL_ADDR, 8'h05, 8'h05);
    rdc("mode 1 byte", SPCU_DATA_ADDR, 8'hFF, 8'h69);
    fork
      peer_u.take(10, 32, bits);
      wr(SPCU_DATA_ADDR, 8'h5C);
    join
    chk("mode 1 frame", {2'b01, 8'h5C, 1'b0}, bits);
    // mode 3 on every second timer overflow, ninth bit set
    wr(SPCU_PWR_ADDR, 8'h00);
    wr(SPCU_CTRL_ADDR, 8'hC8);
    fork
      peer_u.take(11, 64, bits);
      wr(SPCU_DATA_ADDR, 8'hC3);
    join
    chk("mode 3 frame", {2'b11, 8'hC3, 1'b0}, bits);
    // mode 0 shift clock period, filter kept off in this mode
    wr(SPCU_CTRL_ADDR, 8'h00);
    wr(SPCU_DATA_ADDR, 8'h96);
    fork
      // data on the shared pin, taken at each rising shift clock
      for (int i = 0; i < 8; i++) begin
        @(posedge txd_out);
        bits[i] = rxd_line;
      end
      begin
        @(negedge txd_out);
        t0 = $time;
        @(negedge txd_out);
        chk("shift period", 11'h006, 11'(($time - t0) / 100));
      end
    join
    chk("shift data", {3'h0, 8'h96}, {3'h0, bits[7:0]});
    repeat (20) @(posedge clk);
    rdc("mode 0 tx done", SPCU_CTRL_ADDR, 8'h02, 8'h02);
    // mode 0 receive starts by itself once enabled with rx done clear
    fork
      wr(SPCU_CTRL_ADDR, 8'h10);
      peer_u.give(1, 100, 11'h000);
    join
    rdc("mode 0 rx done", SPCU_CTRL_ADDR, 8'h01, 8'h01);
    rdc("mode 0 byte", SPCU_DATA_ADDR, 8'hFF, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
